// [hw/tcs_pkg.sv]
// Package for the tightly coupled SRAM steering block.
// Assumes a 32-bit core address space and word-wide SRAM ports.
package tcs_pkg;
   // Core address and data widths
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;
   // SRAM array depth as word address bits
   localparam int unsigned IRAM_AW = 8;
   localparam int unsigned DRAM_AW = 8;
   // Base addresses of the two SRAM ranges
   localparam logic [31:0] IRAM_BASE = 32'h0000_0000;
   localparam logic [31:0] DRAM_BASE = 32'h0040_0000;
   // Control register field positions
   localparam int unsigned BIT_DRAM_EN = 16;
   localparam int unsigned BIT_DRAM_LOAD = 17;
   localparam int unsigned BIT_IRAM_EN = 18;
   localparam int unsigned BIT_IRAM_LOAD = 19;
   // Combined enable and load masks
   localparam logic [31:0] MASK_IRAM_LOAD_EN = 32'h000c_0000;
   localparam logic [31:0] MASK_DRAM_LOAD_EN = 32'h0003_0000;
   // Reset value of the steering bits
   localparam logic [3:0] CTRL_RESET = 4'h0;
endpackage : tcs_pkg

// [hw/tcs_sram_if.sv]
// Carrier between the steering logic and one SRAM array.
// Assumes a single clock; read data is combinational from the array.
`timescale 1ns/100ps
`default_nettype none
interface tcs_sram_if #(parameter int unsigned AW = 8);
   logic cs;
   logic we;
   logic [AW-1:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   // Steering side drives the port, array side answers
   modport ctrl (output cs, output we, output addr, output wdata, input rdata);
   modport mem (input cs, input we, input addr, input wdata, output rdata);
endinterface : tcs_sram_if
`default_nettype wire

// [hw/tcs_sram.sv]
// Flip-flop SRAM array for one tightly coupled memory.
// Assumes the steering logic registers the read data it forwards.
`timescale 1ns/100ps
`default_nettype none
module tcs_sram #(
   parameter int unsigned AW = 8
) (
   // Clock
   input wire logic clk_sys,
   // Array port
   tcs_sram_if.mem port
);
   logic [31:0] mem_q [0:(1<<AW)-1];

   // No reset on the array, so contents survive enable changes
   always_ff @(posedge clk_sys) begin
      if (port.cs && port.we) begin
         mem_q[port.addr] <= port.wdata;
      end
   end

   // Read by index; the caller flops it for a one-cycle answer
   assign port.rdata = mem_q[port.addr];
endmodule : tcs_sram
`default_nettype wire

// [hw/tcs_steer.sv]
// Access steering for the instruction and data tightly coupled SRAMs.
// Assumes one outstanding request per core side; the core waits for valid.
// Notes on behaviour
// - Outside reset, four control register bits govern both SRAMs.
// - Writing bit 18 as one enables the instruction SRAM.
// - Enabled instruction SRAM serves fetches and data accesses in its range.
// - SRAM accesses complete without stalls, except a fetch that a data access defers a cycle; bus accesses may stall.
// - Clearing bit 18 sends every fetch to the system bus.
// - Disabling an SRAM keeps its contents for later reads.
// - The data side can write the instruction SRAM to fill it.
// - Instruction load mode sends reads in its range to the bus.
// - Writes to the instruction range land in SRAM regardless of load mode.
// - Mask c0000 sets instruction enable and load mode together.
// - Setting bit 16 enables the data SRAM for its whole range.
// - Clearing bit 16 sends data SRAM range accesses to the bus.
// - Data load mode sends reads to the bus, writes still to SRAM.
// - Mask 30000 sets data enable and load mode together.
// - The instruction SRAM sits at address zero, decoded simply.
// - Each SRAM answers reads in a single clock cycle.
`timescale 1ns/100ps
`default_nettype none
module tcs_steer (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // System control coprocessor control register access
   input wire logic ctrl_wr,
   input wire logic [31:0] ctrl_wdata,
   output logic [31:0] ctrl_rdata,
   // Core instruction fetch side
   input wire logic f_req,
   input wire logic [31:0] f_addr,
   output logic f_valid,
   output logic [31:0] f_rdata,
   // Core data side
   input wire logic d_req,
   input wire logic d_wr,
   input wire logic [31:0] d_addr,
   input wire logic [31:0] d_wdata,
   output logic d_valid,
   output logic [31:0] d_rdata,
   // Bus unit, instruction channel
   output logic ibus_req,
   output logic [31:0] ibus_addr,
   input wire logic ibus_done,
   input wire logic [31:0] ibus_rdata,
   // Bus unit, data channel
   output logic dbus_req,
   output logic dbus_wr,
   output logic [31:0] dbus_addr,
   output logic [31:0] dbus_wdata,
   input wire logic dbus_done,
   input wire logic [31:0] dbus_rdata
);
   localparam int unsigned IAW = tcs_pkg::IRAM_AW;
   localparam int unsigned DAW = tcs_pkg::DRAM_AW;

   tcs_sram_if #(.AW(IAW)) iram ();
   tcs_sram_if #(.AW(DAW)) dram ();

   logic [3:0] ctrl_q, ctrl_d;
   logic pend_q, pend_d;
   logic [31:0] pend_addr_q, pend_addr_d;
   logic f_valid_q, d_valid_q, ibus_req_q, dbus_req_q, dbus_wr_q;
   logic [31:0] f_rdata_q, d_rdata_q, ibus_addr_q, dbus_addr_q, dbus_wdata_q;

   // Control bits held in the low nibble, in field order
   wire d_en = ctrl_q[0];
   wire d_load = ctrl_q[1];
   wire i_en = ctrl_q[2];
   wire i_load = ctrl_q[3];

   // Control register write takes the four steering fields only
   assign ctrl_d = ctrl_wr ? {ctrl_wdata[tcs_pkg::BIT_IRAM_LOAD], ctrl_wdata[tcs_pkg::BIT_IRAM_EN],
                              ctrl_wdata[tcs_pkg::BIT_DRAM_LOAD], ctrl_wdata[tcs_pkg::BIT_DRAM_EN]}
                           : ctrl_q;

   // Fetch in flight: a deferred fetch takes precedence over a new one
   wire f_act = pend_q | f_req;
   wire [31:0] f_eff = pend_q ? pend_addr_q : f_addr;

   // Range decode; the instruction range at zero needs only a high-bit compare
   wire f_in_i = (f_eff[31:IAW+2] == tcs_pkg::IRAM_BASE[31:IAW+2]);
   wire d_in_i = (d_addr[31:IAW+2] == tcs_pkg::IRAM_BASE[31:IAW+2]);
   wire d_in_d = (d_addr[31:DAW+2] == tcs_pkg::DRAM_BASE[31:DAW+2]);

   // Load mode inhibits SRAM reads only; writes go in either way
   wire f_to_iram = f_act & f_in_i & i_en & ~i_load;
   wire d_to_iram = d_req & d_in_i & i_en & (d_wr | ~i_load);
   wire d_to_dram = d_req & d_in_d & d_en & (d_wr | ~d_load);
   wire d_to_bus = d_req & ~d_to_iram & ~d_to_dram;

   // Data side wins the shared instruction SRAM port; the fetch waits a cycle
   wire f_conflict = f_to_iram & d_to_iram;
   wire f_go_iram = f_to_iram & ~d_to_iram;
   wire f_to_bus = f_act & ~f_to_iram;

   assign pend_d = f_conflict;
   assign pend_addr_d = f_conflict ? f_eff : pend_addr_q;

   // Instruction SRAM port multiplexed between the two core sides
   assign iram.cs = d_to_iram | f_go_iram;
   assign iram.we = d_to_iram & d_wr;
   assign iram.addr = d_to_iram ? d_addr[IAW+1:2] : f_eff[IAW+1:2];
   assign iram.wdata = d_wdata;

   // Data SRAM port belongs to the data side alone
   assign dram.cs = d_to_dram;
   assign dram.we = d_to_dram & d_wr;
   assign dram.addr = d_addr[DAW+1:2];
   assign dram.wdata = d_wdata;

   // Neither array has a reset, so contents outlive a disable
   tcs_sram #(.AW(IAW)) u_iram (.clk_sys(clk_sys), .port(iram.mem));
   tcs_sram #(.AW(DAW)) u_dram (.clk_sys(clk_sys), .port(dram.mem));

   // Answer selection: SRAM answers next cycle, bus answers the cycle after its done
   wire f_valid_d = f_go_iram | ibus_done;
   wire [31:0] f_rdata_d = f_go_iram ? iram.rdata : ibus_rdata;
   wire d_sram = d_to_iram | d_to_dram;
   wire d_valid_d = d_sram | dbus_done;
   wire [31:0] d_rdata_d = d_to_iram ? iram.rdata : (d_to_dram ? dram.rdata : dbus_rdata);

   // Control state; reset clears all steering bits
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_q <= tcs_pkg::CTRL_RESET;
         pend_q <= 1'b0;
         pend_addr_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         pend_q <= pend_d;
         pend_addr_q <= pend_addr_d;
      end
   end

   // Core answers, registered so outputs come from flops
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         f_valid_q <= 1'b0;
         d_valid_q <= 1'b0;
         f_rdata_q <= 32'h0000_0000;
         d_rdata_q <= 32'h0000_0000;
      end else begin
         f_valid_q <= f_valid_d;
         d_valid_q <= d_valid_d;
         f_rdata_q <= f_rdata_d;
         d_rdata_q <= d_rdata_d;
      end
   end

   // Bus unit requests, one-cycle pulses with held address and data
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ibus_req_q <= 1'b0;
         dbus_req_q <= 1'b0;
         dbus_wr_q <= 1'b0;
         ibus_addr_q <= 32'h0000_0000;
         dbus_addr_q <= 32'h0000_0000;
         dbus_wdata_q <= 32'h0000_0000;
      end else begin
         ibus_req_q <= f_to_bus;
         dbus_req_q <= d_to_bus;
         if (f_to_bus) begin
            ibus_addr_q <= f_eff;
         end
         if (d_to_bus) begin
            dbus_wr_q <= d_wr;
            dbus_addr_q <= d_addr;
            dbus_wdata_q <= d_wdata;
         end
      end
   end

   // Output connections; unimplemented control bits read as zero
   assign ctrl_rdata = {12'h000, ctrl_q, 16'h0000};
   assign f_valid = f_valid_q;
   assign f_rdata = f_rdata_q;
   assign d_valid = d_valid_q;
   assign d_rdata = d_rdata_q;
   assign ibus_req = ibus_req_q;
   assign ibus_addr = ibus_addr_q;
   assign dbus_req = dbus_req_q;
   assign dbus_wr = dbus_wr_q;
   assign dbus_addr = dbus_addr_q;
   assign dbus_wdata = dbus_wdata_q;

   // Checks on steering and timing
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // A deferred fetch whose retry cycle has no data hit on the shared port is answered the cycle after
   sequence s_fetch_deferred;
      f_conflict ##1 (pend_q && !d_to_iram);
   endsequence
   sequence s_fetch_answered;
      f_valid_q;
   endsequence

   property p_reset_clear;
      @(posedge clk_sys) disable iff (1'b0) sys_rst |=> (ctrl_rdata == 32'h0000_0000);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("steering bits not clear after reset");

   property p_iram_enable;
      ctrl_wr && ctrl_wdata[tcs_pkg::BIT_IRAM_EN] |=> ctrl_rdata[tcs_pkg::BIT_IRAM_EN] && i_en;
   endproperty
   a_iram_enable: assert property (p_iram_enable) else $error("bit 18 write did not enable");

   property p_imask;
      ctrl_wr && ((ctrl_wdata & tcs_pkg::MASK_IRAM_LOAD_EN) == tcs_pkg::MASK_IRAM_LOAD_EN)
         |=> i_en && i_load;
   endproperty
   a_imask: assert property (p_imask) else $error("instruction mask did not set both bits");

   property p_dmask;
      ctrl_wr && ((ctrl_wdata & tcs_pkg::MASK_DRAM_LOAD_EN) == tcs_pkg::MASK_DRAM_LOAD_EN)
         |=> d_en && d_load;
   endproperty
   a_dmask: assert property (p_dmask) else $error("data mask did not set both bits");

   property p_fetch_off_bus;
      f_req && !pend_q && !i_en |=> ibus_req && (ibus_addr == $past(f_addr));
   endproperty
   a_fetch_off_bus: assert property (p_fetch_off_bus) else $error("fetch not sent to bus when disabled");

   property p_iram_one_cycle;
      f_go_iram |=> f_valid && (f_rdata == $past(iram.rdata)) && !ibus_req;
   endproperty
   a_iram_one_cycle: assert property (p_iram_one_cycle) else $error("SRAM fetch not answered in one cycle");

   property p_deferred_fetch;
      s_fetch_deferred |=> s_fetch_answered;
   endproperty
   a_deferred_fetch: assert property (p_deferred_fetch) else $error("deferred fetch not served");

   property p_iload_read;
      d_req && !d_wr && d_in_i && i_load |=> dbus_req && !dbus_wr && !d_valid;
   endproperty
   a_iload_read: assert property (p_iload_read) else $error("load mode read used SRAM");

   property p_iload_write;
      d_req && d_wr && d_in_i && i_en |-> iram.cs && iram.we && (iram.addr == d_addr[IAW+1:2]);
   endproperty
   a_iload_write: assert property (p_iload_write) else $error("write to instruction range missed SRAM");

   property p_dram_off;
      d_req && d_in_d && !d_en |=> dbus_req && (dbus_addr == $past(d_addr));
   endproperty
   a_dram_off: assert property (p_dram_off) else $error("disabled data range not sent to bus");

   property p_dload;
      d_req && d_in_d && d_en && d_load |-> (dram.we == d_wr) && (dram.cs == d_wr);
   endproperty
   a_dload: assert property (p_dload) else $error("data load mode steering wrong");
endmodule : tcs_steer
`default_nettype wire

// [sim/tcs_bus_model.sv]
// Behavioural bus unit channel that answers the steering block's bus requests.
// Assumes one outstanding request; the bench sets the answer delay.
`timescale 1ns/100ps
`default_nettype none
module tcs_bus_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Answer delay in cycles
   input wire logic [3:0] dly,
   // Channel from the steering block
   input wire logic req,
   input wire logic wr,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   output logic done,
   output logic [31:0] rdata,
   // Last write seen, for the bench
   output logic [31:0] last_waddr,
   output logic [31:0] last_wdata
);
   int cnt;
   logic [31:0] addr_q;
   // Read data is the inverted address; between answers it wanders so stale data never matches
   always @(posedge clk_sys) begin
      done <= 1'b0;
      rdata <= rdata + 32'h0000_0101;
      if (sys_rst) begin
         cnt <= -1;
         rdata <= 32'h0000_0000;
      end else if (req) begin
         cnt <= int'(dly);
         addr_q <= addr;
         if (wr) begin
            last_waddr <= addr;
            last_wdata <= wdata;
         end
      end else if (cnt == 0) begin
         done <= 1'b1;
         rdata <= ~addr_q;
         cnt <= -1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule : tcs_bus_model
`default_nettype wire

// [sim/tb_tcs_steer.sv]
// Self-checking bench for the tightly coupled SRAM steering block.
// Assumes the bus model answers reads with the inverted address.
`timescale 1ns/100ps
`default_nettype none
module tb_tcs_steer;
   logic clk_sys, sys_rst, ctrl_wr, f_req, d_req, d_wr, ibus_done, dbus_done;
   logic f_valid, d_valid, ibus_req, dbus_req, dbus_wr;
   logic [31:0] ctrl_wdata, ctrl_rdata, f_addr, f_rdata, d_addr, d_wdata, d_rdata, ibus_addr, ibus_rdata;
   logic [31:0] dbus_addr, dbus_wdata, dbus_rdata, wa, wd;
   logic [3:0] dly;
   localparam logic [31:0] DA = tcs_pkg::DRAM_BASE | 32'h0000_0010;
   int fails, samples_checked, cycle_cnt, ireq_cnt, dreq_cnt;
   tcs_steer tcs_steer_i (.clk_sys, .sys_rst, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .f_req, .f_addr, .f_valid,
      .f_rdata, .d_req, .d_wr, .d_addr, .d_wdata, .d_valid, .d_rdata, .ibus_req, .ibus_addr, .ibus_done,
      .ibus_rdata, .dbus_req, .dbus_wr, .dbus_addr, .dbus_wdata, .dbus_done, .dbus_rdata);
   tcs_bus_model ibus_model_i (.clk_sys, .sys_rst, .dly, .req(ibus_req), .wr(1'b0), .addr(ibus_addr),
      .wdata(32'h0000_0000), .done(ibus_done), .rdata(ibus_rdata), .last_waddr(), .last_wdata());
   tcs_bus_model dbus_model_i (.clk_sys, .sys_rst, .dly, .req(dbus_req), .wr(dbus_wr), .addr(dbus_addr),
      .wdata(dbus_wdata), .done(dbus_done), .rdata(dbus_rdata), .last_waddr(wa), .last_wdata(wd));
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Bus request counters and hang guard; the run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cycle_cnt++;
      if (ibus_req === 1'b1) ireq_cnt++;
      if (dbus_req === 1'b1) dreq_cnt++;
      if (cycle_cnt == 5000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   // Control write as read-modify-write of the current image
   task automatic wctrl(input logic [31:0] set, input logic [31:0] clr, input logic [31:0] exp);
      ctrl_wr = 1'b1;
      ctrl_wdata = (ctrl_rdata | set) & ~clr;
      @(negedge clk_sys);
      ctrl_wr = 1'b0;
      check(ctrl_rdata, exp);
      // Idle edge so a following strobe never rises in the step that lowered it
      @(negedge clk_sys);
   endtask : wctrl
   // One fetch; bus says whether a bus request is expected
   task automatic fetch(input logic [31:0] a, input logic bus, input logic [31:0] exp);
      int n;
      int b0;
      b0 = ireq_cnt;
      f_req = 1'b1;
      f_addr = a;
      @(negedge clk_sys);
      f_req = 1'b0;
      n = 1;
      while (f_valid !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      check(32'(ireq_cnt - b0), {31'h0, bus});
      if (!bus) check(32'(n), 32'h0000_0001);
      check(f_rdata, exp);
      @(negedge clk_sys);
   endtask : fetch
   // One data access; reads also compare the returned word
   task automatic dacc(input logic wr, input logic [31:0] a, input logic [31:0] wdat, input logic bus,
         input logic [31:0] exp);
      int n;
      int b0;
      b0 = dreq_cnt;
      d_req = 1'b1;
      d_wr = wr;
      d_addr = a;
      d_wdata = wdat;
      @(negedge clk_sys);
      d_req = 1'b0;
      n = 1;
      while (d_valid !== 1'b1 && n < 40) begin
         @(negedge clk_sys);
         n++;
      end
      check(32'(dreq_cnt - b0), {31'h0, bus});
      if (!bus) check(32'(n), 32'h0000_0001);
      if (!wr) check(d_rdata, exp);
      @(negedge clk_sys);
   endtask : dacc
   // After reset every access goes to the bus
   task automatic t_reset();
      @(negedge clk_sys);
      check(ctrl_rdata, 32'h0000_0000);
      fetch(32'h0000_0010, 1'b1, ~32'h0000_0010);
      dacc(1'b0, DA, 32'h0000_0000, 1'b1, ~DA);
   endtask : t_reset
   // Only the four steering bits are kept; combined masks set pairs
   task automatic t_ctrl();
      wctrl(32'hffff_ffff, 32'h0000_0000, 32'h000f_0000);
      wctrl(32'h0000_0000, 32'hffff_ffff, 32'h0000_0000);
      wctrl(32'h000c_0000, 32'h0000_0000, 32'h000c_0000);
      wctrl(32'h0000_0000, 32'hffff_ffff, 32'h0000_0000);
      wctrl(32'h0003_0000, 32'h0000_0000, 32'h0003_0000);
      wctrl(32'h0000_0000, 32'hffff_ffff, 32'h0000_0000);
   endtask : t_ctrl
   // Instruction SRAM fill in load mode, use, disable and retention
   task automatic t_iram();
      dly = 4'h3;
      wctrl(32'h000c_0000, 32'h0000_0000, 32'h000c_0000);
      for (int i = 0; i < 2; i++) begin
         dacc(1'b0, 32'h20 + 4 * i, 32'h0000_0000, 1'b1, ~(32'h20 + 4 * i));
         dacc(1'b1, 32'h20 + 4 * i, ~(32'h20 + 4 * i), 1'b0, 32'h0000_0000);
      end
      fetch(32'h0000_0020, 1'b1, ~32'h0000_0020);
      wctrl(32'h0000_0000, 32'h0008_0000, 32'h0004_0000);
      fetch(32'h0000_0020, 1'b0, ~32'h0000_0020);
      dacc(1'b0, 32'h0000_0024, 32'h0000_0000, 1'b0, ~32'h0000_0024);
      dacc(1'b1, 32'h0000_0024, 32'h1234_5678, 1'b0, 32'h0000_0000);
      fetch(32'h0000_0024, 1'b0, 32'h1234_5678);
      wctrl(32'h0000_0000, 32'h0004_0000, 32'h0000_0000);
      fetch(32'h0000_0024, 1'b1, ~32'h0000_0024);
      wctrl(32'h0004_0000, 32'h0000_0000, 32'h0004_0000);
      fetch(32'h0000_0024, 1'b0, 32'h1234_5678);
   endtask : t_iram
   // Data SRAM enable, load mode and disable
   task automatic t_dram();
      dly = 4'h0;
      wctrl(32'h0001_0000, 32'h0000_0000, 32'h0005_0000);
      dacc(1'b1, DA, 32'hcafe_0001, 1'b0, 32'h0000_0000);
      dacc(1'b0, DA, 32'h0000_0000, 1'b0, 32'hcafe_0001);
      wctrl(32'h0002_0000, 32'h0000_0000, 32'h0007_0000);
      dacc(1'b0, DA, 32'h0000_0000, 1'b1, ~DA);
      dacc(1'b1, DA, 32'h5a5a_a5a5, 1'b0, 32'h0000_0000);
      wctrl(32'h0000_0000, 32'h0002_0000, 32'h0005_0000);
      dacc(1'b0, DA, 32'h0000_0000, 1'b0, 32'h5a5a_a5a5);
      wctrl(32'h0000_0000, 32'h0001_0000, 32'h0004_0000);
      dacc(1'b1, DA, 32'h0bad_0002, 1'b1, 32'h0000_0000);
      check(wa, DA);
      check(wd, 32'h0bad_0002);
      dacc(1'b0, DA, 32'h0000_0000, 1'b1, ~DA);
   endtask : t_dram
   // Mid-run reset clears the steering bits but leaves the instruction array intact
   task automatic t_rst_mid();
      sys_rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      check(ctrl_rdata, 32'h0000_0000);
      fetch(32'h0000_0024, 1'b1, ~32'h0000_0024);
      wctrl(32'h0004_0000, 32'h0000_0000, 32'h0004_0000);
      fetch(32'h0000_0024, 1'b0, 32'h1234_5678);
   endtask : t_rst_mid
   // Fetch and data read meet at the instruction SRAM; data wins, the fetch follows a cycle later
   task automatic t_conflict();
      int b0;
      b0 = ireq_cnt;
      f_req = 1'b1;
      f_addr = 32'h0000_0024;
      d_req = 1'b1;
      d_wr = 1'b0;
      d_addr = 32'h0000_0020;
      @(negedge clk_sys);
      f_req = 1'b0;
      d_req = 1'b0;
      check({31'h0, d_valid}, 32'h0000_0001);
      check(d_rdata, ~32'h0000_0020);
      check({31'h0, f_valid}, 32'h0000_0000);
      @(negedge clk_sys);
      check({31'h0, f_valid}, 32'h0000_0001);
      check(f_rdata, 32'h1234_5678);
      check(32'(ireq_cnt - b0), 32'h0000_0000);
   endtask : t_conflict
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      ctrl_wr = 1'b0;
      ctrl_wdata = 32'h0000_0000;
      f_req = 1'b0;
      f_addr = 32'h0000_0000;
      d_req = 1'b0;
      d_wr = 1'b0;
      d_addr = 32'h0000_0000;
      d_wdata = 32'h0000_0000;
      dly = 4'h0;
      fails = 0;
      samples_checked = 0;
      cycle_cnt = 0;
      ireq_cnt = 0;
      dreq_cnt = 0;
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_reset();
      t_ctrl();
      t_iram();
      t_dram();
      t_rst_mid();
      t_conflict();
      print_verdict();
   end
endmodule : tb_tcs_steer
`default_nettype wire
